// File: pkg/agm_consts.vh
// Register map, field positions, reset values and rates of the gain/mute filter
`ifndef AGM_CONSTS_VH
`define AGM_CONSTS_VH
// Register indices; byte address is four times the index
`define AGM_IDX_PB_VOL_L   8'h32
`define AGM_IDX_PB_VOL_R   8'h33
`define AGM_IDX_PB_MUTE    8'h3a
`define AGM_IDX_PB_RAMP    8'h3b
`define AGM_IDX_PB_SIDE    8'h3c
`define AGM_IDX_REC_CTRL   8'h40
`define AGM_IDX_REC_VOL_L  8'h42
`define AGM_IDX_REC_VOL_R  8'h43
`define AGM_IDX_ST_LEVEL   8'h44
`define AGM_IDX_STATUS     8'h45
// Field positions
`define AGM_B_MUTE         14
`define AGM_B_UNMUTE_MODE  14
`define AGM_B_RAMP_RATE    13
`define AGM_B_STOPBAND     12
`define AGM_F_SRC_L        13:12
`define AGM_F_SRC_R        11:10
`define AGM_B_HPF_EN       15
`define AGM_F_HPF_CUT      9:8
`define AGM_B_INV_L        1
`define AGM_B_INV_R        0
`define AGM_B_CH_EN        15
`define AGM_B_COMMIT       8
`define AGM_F_GAIN         7:0
`define AGM_F_ST_LVL_L     11:8
`define AGM_F_ST_LVL_R     7:4
// Reset values
`define AGM_RST_MUTE       1'b1
`define AGM_RST_HPF_EN     1'b1
`define AGM_RST_GAIN       8'hc0
// Side-tone source codes
`define AGM_SRC_NONE       2'h0
`define AGM_SRC_LEFT       2'h1
`define AGM_SRC_RIGHT      2'h2
// Soft-mute ramp step rates against the sample rate, in Hz
`define AGM_FS_HZ          48000
`define AGM_FAST_HZ        24000
`define AGM_SLOW_HZ        1500
// High-pass coefficient shifts per cut-off code
`define AGM_HPF_K0         5'h0b
`define AGM_HPF_K1         5'h05
`define AGM_HPF_K2         5'h04
`define AGM_HPF_K3         5'h03
// Gain code exponent at 0 dB, side-tone level code at 0 dB
`define AGM_GAIN_UNITY_EXP 4'hc
`define AGM_ST_UNITY_CODE  4'hc
`endif

// File: logic/agm_filter.v
// Playback soft mute, side-tone mix and record high-pass, polarity and volume
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "agm_consts.vh"

module agm_filter
#(
  parameter AW = 10
)
(
  input  wire                  ref_clk,
  input  wire                  reset_n,
  input  wire [AW-1:0]         address,
  input  wire                  read,
  input  wire                  write,
  input  wire [3:0]            byteenable,
  input  wire [31:0]           writedata,
  output wire [31:0]           readdata,
  output wire                  waitrequest,
  input  wire                  play_valid,
  input  wire signed [15:0]    play_left_in,
  input  wire signed [15:0]    play_right_in,
  output wire                  play_out_valid,
  output wire signed [15:0]    playback_left_channel,
  output wire signed [15:0]    playback_right_channel,
  input  wire                  rec_valid,
  input  wire signed [15:0]    rec_left_in,
  input  wire signed [15:0]    rec_right_in,
  output wire                  record_left_valid,
  output wire                  record_right_valid,
  output wire signed [15:0]    record_left_channel,
  output wire signed [15:0]    record_right_channel
);

  localparam integer FAST_DIV = `AGM_FS_HZ / `AGM_FAST_HZ;
  localparam integer SLOW_DIV = `AGM_FS_HZ / `AGM_SLOW_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function signed [15:0] sat16;
    input signed [47:0] v;
    begin
      if (v > 48'sh7fff)
        sat16 = 16'sh7fff;
      else if (v < -48'sh8000)
        sat16 = 16'sh8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    begin
      merge16[7:0]  = be[0] ? wd[7:0] : old[7:0];
      merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // Gain code: 0 mute, 1 is -71.625 dB, 0.375 dB a step, c0 is 0 dB
  function signed [15:0] vol_apply;
    input signed [15:0] x;
    input [7:0]         code;
    reg [15:0]          m;
    reg signed [47:0]   p;
    begin
      case (code[3:0])
        4'h0: m = 16'h4000;
        4'h1: m = 16'h42d5;
        4'h2: m = 16'h45ca;
        4'h3: m = 16'h48e1;
        4'h4: m = 16'h4c1c;
        4'h5: m = 16'h4f7a;
        4'h6: m = 16'h52ff;
        4'h7: m = 16'h56ac;
        4'h8: m = 16'h5a82;
        4'h9: m = 16'h5e84;
        4'ha: m = 16'h62b3;
        4'hb: m = 16'h6712;
        4'hc: m = 16'h6ba2;
        4'hd: m = 16'h7066;
        4'he: m = 16'h7560;
        default: m = 16'h7a93;
      endcase
      p = x * $signed({1'b0, m});
      if (code == 8'h00)
        p = 48'sh0;
      else if (code[7:4] >= `AGM_GAIN_UNITY_EXP)
        p = p <<< (code[7:4] - `AGM_GAIN_UNITY_EXP);
      else
        p = p >>> (`AGM_GAIN_UNITY_EXP - code[7:4]);
      vol_apply = sat16(p >>> 14);
    end
  endfunction

  // Side-tone level: 0 is -36 dB, c and above 0 dB, 3 dB a step
  function signed [15:0] lvl_apply;
    input signed [15:0] x;
    input [3:0]         code;
    reg [15:0]          m;
    reg signed [47:0]   p;
    begin
      case (code)
        4'h0: m = 16'h0104;
        4'h1: m = 16'h016f;
        4'h2: m = 16'h0206;
        4'h3: m = 16'h02dc;
        4'h4: m = 16'h040a;
        4'h5: m = 16'h05b4;
        4'h6: m = 16'h080f;
        4'h7: m = 16'h0b61;
        4'h8: m = 16'h1013;
        4'h9: m = 16'h16c5;
        4'ha: m = 16'h2013;
        4'hb: m = 16'h2d4f;
        default: m = 16'h4000;
      endcase
      p = x * $signed({1'b0, m});
      lvl_apply = sat16(p >>> 14);
    end
  endfunction

  function [4:0] hpf_shift;
    input [1:0] cut;
    begin
      case (cut)
        2'h0: hpf_shift = `AGM_HPF_K0;
        2'h1: hpf_shift = `AGM_HPF_K1;
        2'h2: hpf_shift = `AGM_HPF_K2;
        default: hpf_shift = `AGM_HPF_K3;
      endcase
    end
  endfunction

  function signed [15:0] neg_sat;
    input signed [15:0] x;
    begin
      neg_sat = (x == 16'sh8000) ? 16'sh7fff : -x;
    end
  endfunction

  function signed [15:0] sidetone;
    input [1:0]         src;
    input signed [15:0] l;
    input signed [15:0] r;
    input [3:0]         lvl;
    begin
      case (src)
        `AGM_SRC_LEFT:  sidetone = lvl_apply(l, lvl);
        `AGM_SRC_RIGHT: sidetone = lvl_apply(r, lvl);
        default:        sidetone = 16'sh0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg        waitrequest_ff;
  reg [31:0] readdata_ff;
  reg        mute_ff;
  reg        unmute_mode_ff;
  reg        ramp_rate_ff;
  reg        stopband_ff;
  reg [1:0]  src_l_ff;
  reg [1:0]  src_r_ff;
  reg [7:0]  pb_stage_l_ff;
  reg [7:0]  pb_stage_r_ff;
  reg [7:0]  pb_live_l_ff;
  reg [7:0]  pb_live_r_ff;
  reg [7:0]  pb_cur_l_ff;
  reg [7:0]  pb_cur_r_ff;
  reg        hpf_en_ff;
  reg [1:0]  hpf_cut_ff;
  reg        inv_l_ff;
  reg        inv_r_ff;
  reg        rec_en_l_ff;
  reg        rec_en_r_ff;
  reg [7:0]  rec_stage_l_ff;
  reg [7:0]  rec_stage_r_ff;
  reg [7:0]  rec_live_l_ff;
  reg [7:0]  rec_live_r_ff;
  reg [3:0]  st_lvl_l_ff;
  reg [3:0]  st_lvl_r_ff;
  reg [31:0] ramp_cnt_ff;
  reg signed [15:0] prev_l_ff;
  reg signed [15:0] prev_r_ff;
  reg signed [31:0] dc1_l_ff;
  reg signed [31:0] dc2_l_ff;
  reg signed [31:0] dc1_r_ff;
  reg signed [31:0] dc2_r_ff;
  reg        play_out_valid_ff;
  reg signed [15:0] play_l_ff;
  reg signed [15:0] play_r_ff;
  reg        rec_l_valid_ff;
  reg        rec_r_valid_ff;
  reg signed [15:0] rec_l_ff;
  reg signed [15:0] rec_r_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then accept

  wire [7:0]  idx    = address[AW-1:2];
  wire        wr_ok  = write & ~waitrequest_ff;
  reg  [15:0] rd_val;
  wire [15:0] wm     = merge16(rd_val, writedata[15:0], byteenable[1:0]);
  wire        commit = wr_ok & byteenable[1] & writedata[`AGM_B_COMMIT];
  wire        rec_commit = commit & ((idx == `AGM_IDX_REC_VOL_L) |
                                     (idx == `AGM_IDX_REC_VOL_R));
  wire        pb_commit  = commit & ((idx == `AGM_IDX_PB_VOL_L) |
                                     (idx == `AGM_IDX_PB_VOL_R));

  always @*
  begin
    rd_val = 16'h0000;
    case (idx)
      `AGM_IDX_PB_VOL_L:  rd_val = {8'h00, pb_stage_l_ff};
      `AGM_IDX_PB_VOL_R:  rd_val = {8'h00, pb_stage_r_ff};
      `AGM_IDX_PB_MUTE:   rd_val = {1'b0, mute_ff, 14'h0000};
      `AGM_IDX_PB_RAMP:   rd_val = {1'b0, unmute_mode_ff, ramp_rate_ff, stopband_ff, 12'h000};
      `AGM_IDX_PB_SIDE:   rd_val = {2'h0, src_l_ff, src_r_ff, 10'h000};
      `AGM_IDX_REC_CTRL:  rd_val = {hpf_en_ff, 5'h00, hpf_cut_ff, 6'h00, inv_l_ff, inv_r_ff};
      `AGM_IDX_REC_VOL_L: rd_val = {rec_en_l_ff, 7'h00, rec_stage_l_ff};
      `AGM_IDX_REC_VOL_R: rd_val = {rec_en_r_ff, 7'h00, rec_stage_r_ff};
      `AGM_IDX_ST_LEVEL:  rd_val = {4'h0, st_lvl_l_ff, st_lvl_r_ff, 4'h0};
      `AGM_IDX_STATUS:    rd_val = {pb_cur_r_ff, pb_cur_l_ff};
      default:            rd_val = 16'h0000;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest_ff <= 1'b1;
      readdata_ff    <= 32'h00000000;
    end
    else
    begin
      waitrequest_ff <= ~((read | write) & waitrequest_ff);
      if ((read | write) & waitrequest_ff)
        readdata_ff <= {16'h0000, rd_val};
    end
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mute_ff        <= `AGM_RST_MUTE;
      unmute_mode_ff <= 1'b0;
      ramp_rate_ff   <= 1'b0;
      stopband_ff    <= 1'b0;
      src_l_ff       <= `AGM_SRC_NONE;
      src_r_ff       <= `AGM_SRC_NONE;
      pb_stage_l_ff  <= `AGM_RST_GAIN;
      pb_stage_r_ff  <= `AGM_RST_GAIN;
      pb_live_l_ff   <= `AGM_RST_GAIN;
      pb_live_r_ff   <= `AGM_RST_GAIN;
      hpf_en_ff      <= `AGM_RST_HPF_EN;
      hpf_cut_ff     <= 2'h0;
      inv_l_ff       <= 1'b0;
      inv_r_ff       <= 1'b0;
      rec_en_l_ff    <= 1'b0;
      rec_en_r_ff    <= 1'b0;
      rec_stage_l_ff <= `AGM_RST_GAIN;
      rec_stage_r_ff <= `AGM_RST_GAIN;
      rec_live_l_ff  <= `AGM_RST_GAIN;
      rec_live_r_ff  <= `AGM_RST_GAIN;
      st_lvl_l_ff    <= 4'h0;
      st_lvl_r_ff    <= 4'h0;
    end
    else
    begin
      if (wr_ok)
      begin
        case (idx)
          `AGM_IDX_PB_VOL_L:  pb_stage_l_ff <= wm[`AGM_F_GAIN];
          `AGM_IDX_PB_VOL_R:  pb_stage_r_ff <= wm[`AGM_F_GAIN];
          `AGM_IDX_PB_MUTE:   mute_ff <= wm[`AGM_B_MUTE];
          `AGM_IDX_PB_RAMP:
          begin
            unmute_mode_ff <= wm[`AGM_B_UNMUTE_MODE];
            ramp_rate_ff   <= wm[`AGM_B_RAMP_RATE];
            stopband_ff    <= wm[`AGM_B_STOPBAND];
          end
          `AGM_IDX_PB_SIDE:
          begin
            src_l_ff <= wm[`AGM_F_SRC_L];
            src_r_ff <= wm[`AGM_F_SRC_R];
          end
          `AGM_IDX_REC_CTRL:
          begin
            hpf_en_ff  <= wm[`AGM_B_HPF_EN];
            hpf_cut_ff <= wm[`AGM_F_HPF_CUT];
            inv_l_ff   <= wm[`AGM_B_INV_L];
            inv_r_ff   <= wm[`AGM_B_INV_R];
          end
          `AGM_IDX_REC_VOL_L:
          begin
            rec_en_l_ff    <= wm[`AGM_B_CH_EN];
            rec_stage_l_ff <= wm[`AGM_F_GAIN];
          end
          `AGM_IDX_REC_VOL_R:
          begin
            rec_en_r_ff    <= wm[`AGM_B_CH_EN];
            rec_stage_r_ff <= wm[`AGM_F_GAIN];
          end
          `AGM_IDX_ST_LEVEL:
          begin
            st_lvl_l_ff <= wm[`AGM_F_ST_LVL_L];
            st_lvl_r_ff <= wm[`AGM_F_ST_LVL_R];
          end
          default:
          begin
          end
        endcase
      end
      if (rec_commit)
      begin
        rec_live_l_ff <= (idx == `AGM_IDX_REC_VOL_L) ? wm[`AGM_F_GAIN] : rec_stage_l_ff;
        rec_live_r_ff <= (idx == `AGM_IDX_REC_VOL_R) ? wm[`AGM_F_GAIN] : rec_stage_r_ff;
      end
      if (pb_commit)
      begin
        pb_live_l_ff <= (idx == `AGM_IDX_PB_VOL_L) ? wm[`AGM_F_GAIN] : pb_stage_l_ff;
        pb_live_r_ff <= (idx == `AGM_IDX_PB_VOL_R) ? wm[`AGM_F_GAIN] : pb_stage_r_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft mute gain ramp

  wire [31:0] ramp_last = ramp_rate_ff ? (SLOW_DIV - 1) : (FAST_DIV - 1);
  wire        ramp_tick = play_valid & (ramp_cnt_ff >= ramp_last);

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ramp_cnt_ff <= 32'h00000000;
      pb_cur_l_ff <= 8'h00;
      pb_cur_r_ff <= 8'h00;
    end
    else
    begin
      if (play_valid)
        ramp_cnt_ff <= ramp_tick ? 32'h00000000 : ramp_cnt_ff + 32'h00000001;
      if (mute_ff)
      begin
        pb_cur_l_ff <= 8'h00;
        pb_cur_r_ff <= 8'h00;
      end
      else if (!unmute_mode_ff)
      begin
        pb_cur_l_ff <= pb_live_l_ff;
        pb_cur_r_ff <= pb_live_r_ff;
      end
      else if (ramp_tick)
      begin
        if (pb_cur_l_ff < pb_live_l_ff)
          pb_cur_l_ff <= pb_cur_l_ff + 8'h01;
        else if (pb_cur_l_ff > pb_live_l_ff)
          pb_cur_l_ff <= pb_cur_l_ff - 8'h01;
        if (pb_cur_r_ff < pb_live_r_ff)
          pb_cur_r_ff <= pb_cur_r_ff + 8'h01;
        else if (pb_cur_r_ff > pb_live_r_ff)
          pb_cur_r_ff <= pb_cur_r_ff - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Playback path

  wire signed [16:0] avg_l = play_left_in + prev_l_ff;
  wire signed [16:0] avg_r = play_right_in + prev_r_ff;
  wire signed [15:0] flt_l = stopband_ff ? avg_l[16:1] : play_left_in;
  wire signed [15:0] flt_r = stopband_ff ? avg_r[16:1] : play_right_in;
  wire signed [15:0] g_l   = vol_apply(flt_l, pb_cur_l_ff);
  wire signed [15:0] g_r   = vol_apply(flt_r, pb_cur_r_ff);
  wire signed [15:0] st_l  = sidetone(src_l_ff, rec_l_ff, rec_r_ff, st_lvl_l_ff);
  wire signed [15:0] st_r  = sidetone(src_r_ff, rec_l_ff, rec_r_ff, st_lvl_r_ff);
  wire signed [47:0] sum_l = g_l + st_l;
  wire signed [47:0] sum_r = g_r + st_r;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_l_ff         <= 16'sh0;
      prev_r_ff         <= 16'sh0;
      play_out_valid_ff <= 1'b0;
      play_l_ff         <= 16'sh0;
      play_r_ff         <= 16'sh0;
    end
    else
    begin
      play_out_valid_ff <= play_valid;
      if (play_valid)
      begin
        prev_l_ff <= play_left_in;
        prev_r_ff <= play_right_in;
        play_l_ff <= mute_ff ? 16'sh0 : sat16(sum_l);
        play_r_ff <= mute_ff ? 16'sh0 : sat16(sum_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record path: high-pass, polarity, volume

  wire [4:0]         k     = hpf_shift(hpf_cut_ff);
  wire               ord2  = (hpf_cut_ff != 2'h0);
  wire signed [31:0] e1_l  = {rec_left_in[15], rec_left_in, 15'h0000} - dc1_l_ff;
  wire signed [31:0] e2_l  = e1_l - dc2_l_ff;
  wire signed [31:0] e1_r  = {rec_right_in[15], rec_right_in, 15'h0000} - dc1_r_ff;
  wire signed [31:0] e2_r  = e1_r - dc2_r_ff;
  wire signed [31:0] hp_l  = ord2 ? e2_l : e1_l;
  wire signed [31:0] hp_r  = ord2 ? e2_r : e1_r;
  wire signed [15:0] h_l   = hpf_en_ff ? sat16(hp_l >>> 15) : rec_left_in;
  wire signed [15:0] h_r   = hpf_en_ff ? sat16(hp_r >>> 15) : rec_right_in;
  wire signed [15:0] p_l   = inv_l_ff ? neg_sat(h_l) : h_l;
  wire signed [15:0] p_r   = inv_r_ff ? neg_sat(h_r) : h_r;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dc1_l_ff       <= 32'sh0;
      dc2_l_ff       <= 32'sh0;
      dc1_r_ff       <= 32'sh0;
      dc2_r_ff       <= 32'sh0;
      rec_l_valid_ff <= 1'b0;
      rec_r_valid_ff <= 1'b0;
      rec_l_ff       <= 16'sh0;
      rec_r_ff       <= 16'sh0;
    end
    else
    begin
      rec_l_valid_ff <= rec_valid & rec_en_l_ff;
      rec_r_valid_ff <= rec_valid & rec_en_r_ff;
      if (rec_valid & rec_en_l_ff)
      begin
        rec_l_ff <= vol_apply(p_l, rec_live_l_ff);
        if (hpf_en_ff)
        begin
          dc1_l_ff <= dc1_l_ff + (e1_l >>> k);
          dc2_l_ff <= ord2 ? dc2_l_ff + (e2_l >>> k) : 32'sh0;
        end
      end
      if (rec_valid & rec_en_r_ff)
      begin
        rec_r_ff <= vol_apply(p_r, rec_live_r_ff);
        if (hpf_en_ff)
        begin
          dc1_r_ff <= dc1_r_ff + (e1_r >>> k);
          dc2_r_ff <= ord2 ? dc2_r_ff + (e2_r >>> k) : 32'sh0;
        end
      end
    end
  end

  assign readdata               = readdata_ff;
  assign waitrequest            = waitrequest_ff;
  assign play_out_valid         = play_out_valid_ff;
  assign playback_left_channel  = play_l_ff;
  assign playback_right_channel = play_r_ff;
  assign record_left_valid      = rec_l_valid_ff;
  assign record_right_valid     = rec_r_valid_ff;
  assign record_left_channel    = rec_l_ff;
  assign record_right_channel   = rec_r_ff;

endmodule

// File: verif/agm_filter_asserts.sv
// Port checker for the gain, mute and filter block
`timescale 1ns/1ps
module agm_filter_asserts
#(
  parameter AW = 10
)
(
  input wire               ref_clk,
  input wire               reset_n,
  input wire               read,
  input wire               write,
  input wire [31:0]        readdata,
  input wire               waitrequest,
  input wire               play_valid,
  input wire               play_out_valid,
  input wire signed [15:0] playback_left_channel,
  input wire signed [15:0] playback_right_channel,
  input wire               rec_valid,
  input wire               record_left_valid,
  input wire               record_right_valid,
  input wire signed [15:0] record_left_channel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  a_play_out_lat: assert property (play_valid |=> play_out_valid)
    else $error("playback output missing");
  a_play_no_spur: assert property (!play_valid |=> !play_out_valid)
    else $error("playback output without sample");
  a_play_hold_l: assert property (!play_out_valid |-> $stable(playback_left_channel))
    else $error("left playback changed between samples");
  a_play_hold_r: assert property (!play_out_valid |-> $stable(playback_right_channel))
    else $error("right playback changed between samples");
  a_rec_l_cause: assert property (record_left_valid |-> $past(rec_valid))
    else $error("left record sample without strobe");
  a_rec_r_cause: assert property (record_right_valid |-> $past(rec_valid))
    else $error("right record sample without strobe");
  a_rec_hold_l: assert property (!record_left_valid |-> $stable(record_left_channel))
    else $error("left record changed between samples");
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  a_bus_idle: assert property (!(read || write) |=> waitrequest)
    else $error("bus answer without request");
  a_rdata_upper: assert property (!waitrequest |-> readdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
endmodule
bind agm_filter agm_filter_asserts #(.AW(AW)) u_chk
(
  .ref_clk                (ref_clk),
  .reset_n                (reset_n),
  .read                   (read),
  .write                  (write),
  .readdata               (readdata),
  .waitrequest            (waitrequest),
  .play_valid             (play_valid),
  .play_out_valid         (play_out_valid),
  .playback_left_channel  (playback_left_channel),
  .playback_right_channel (playback_right_channel),
  .rec_valid              (rec_valid),
  .record_left_valid      (record_left_valid),
  .record_right_valid     (record_right_valid),
  .record_left_channel    (record_left_channel)
);

// File: verif/agm_stream_src.sv
// Converter-side sample source for playback and record streams
`timescale 1ns/1ps
module agm_stream_src
(
  input  wire               ref_clk,
  input  wire               reset_n,
  input  wire               fixed,
  input  wire signed [15:0] fix_val,
  output reg                play_valid = 1'b0,
  output reg  signed [15:0] play_left_in = 16'h0,
  output reg  signed [15:0] play_right_in = 16'h0,
  output reg                rec_valid = 1'b0,
  output reg  signed [15:0] rec_left_in = 16'h0,
  output reg  signed [15:0] rec_right_in = 16'h0
);
  integer   seed = 36096;
  reg [2:0] ph_ff;
  // One strobe each per eight cycles, data churns in between unless fixed is set
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      ph_ff <= 3'h0;
      play_valid <= 1'b0;
      rec_valid <= 1'b0;
    end
    else
    begin
      ph_ff <= ph_ff + 3'h1;
      rec_valid <= ph_ff == 3'h7;
      play_valid <= ph_ff == 3'h3;
      play_left_in <= fixed ? fix_val : 16'($random(seed));
      play_right_in <= fixed ? fix_val : 16'($random(seed));
      rec_left_in <= fixed ? fix_val : 16'($random(seed));
      rec_right_in <= fixed ? fix_val : 16'($random(seed));
    end
endmodule

// File: verif/tb.sv
// Self-checking bench for the gain, mute and filter block
`timescale 1ns/1ps
module tb;
  localparam integer NA = -100000;
  reg                ref_clk = 1'b0;
  reg                reset_n = 1'b0;
  reg  [9:0]         address = 10'h0;
  reg                read = 1'b0;
  reg                write = 1'b0;
  reg  [31:0]        writedata = 32'h0;
  wire [31:0]        readdata;
  wire               waitrequest;
  wire               play_valid, play_out_valid, rec_valid, rlv, rrv;
  wire signed [15:0] pli, pri, pol, por, rli, rri, rlo, rro;
  reg                fixed = 1'b1;
  reg  signed [15:0] fix_val = 16'sd1000;
  reg  [31:0]        rd;
  reg                mute = 1, sb = 0, hpf = 1, invl = 0, invr = 0, enl = 0, enr = 0;
  reg                pk = 1, rchk = 0, ok;
  reg  [1:0]         srcl = 0, srcr = 0;
  reg  [7:0]         gl_st = 8'hc0, gr_st = 8'hc0, gl = 8'hc0, gr = 8'hc0;
  reg  [7:0]         ri [0:6] = '{8'h3a, 8'h3b, 8'h3c, 8'h40, 8'h42, 8'h43, 8'h10};
  reg  [15:0]        re [0:6] = '{16'h4000, 0, 0, 16'h8000, 16'h00c0, 16'h00c0, 0};
  integer            err_count = 0, checks = 0, cyc = 0, wr_cyc = 0, i;
  integer            el, er, pxl = 0, pxr = 0, ml = 0, mr = 0;
  int                pq[$];

  always #50 ref_clk = ~ref_clk;

  agm_filter #(.AW(10)) dut
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .byteenable(4'h3), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .play_valid(play_valid), .play_left_in(pli), .play_right_in(pri),
    .play_out_valid(play_out_valid), .playback_left_channel(pol),
    .playback_right_channel(por), .rec_valid(rec_valid), .rec_left_in(rli),
    .rec_right_in(rri), .record_left_valid(rlv), .record_right_valid(rrv),
    .record_left_channel(rlo), .record_right_channel(rro)
  );
  agm_stream_src u_src
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .fixed(fixed), .fix_val(fix_val),
    .play_valid(play_valid), .play_left_in(pli), .play_right_in(pri),
    .rec_valid(rec_valid), .rec_left_in(rli), .rec_right_in(rri)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function integer sat(input integer v);
    sat = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
  endfunction
  function integer recx(input integer x, input reg inv, input [7:0] g);
    recx = g == 8'h0 ? 0 : inv ? sat(-x) : x;
  endfunction
  function integer pexp(input integer x, input integer p, input [1:0] s);
    pexp = mute ? 0 : sat((sb ? (x + p) >>> 1 : x) + (s == 1 ? ml : s == 2 ? mr : 0));
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    checks = checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Avalon request held until waitrequest is sampled low
  task bus(input reg wr, input [7:0] idx, input [15:0] wd);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= {16'h0, wd};
    @(posedge ref_clk);
    while (waitrequest !== 1'b0)
      @(posedge ref_clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    wr_cyc = cyc;
    if (wr)
    begin
      case (idx)
        8'h3a: mute = wd[14];
        8'h3b: sb = wd[12];
        8'h3c: {srcl, srcr} = wd[13:10];
        8'h40: {hpf, invl, invr} = {wd[15], wd[1:0]};
        8'h42: {enl, gl_st} = {wd[15], wd[7:0]};
        8'h43: {enr, gr_st} = {wd[15], wd[7:0]};
        default: ;
      endcase
      if ((idx == 8'h42 || idx == 8'h43) && wd[8])
        {gl, gr} = {gl_st, gr_st};
    end
  endtask
  task run(input integer n);
    repeat (8 * n) @(posedge ref_clk);
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reference model scored at stream results; skips NA playback, records near bus writes, and record data with high-pass on
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (play_out_valid === 1'b1 && pq.size() > 1)
    begin
      el = pq.pop_front();
      er = pq.pop_front();
      if (el != NA) chk("play_l", el[15:0], pol);
      if (er != NA) chk("play_r", er[15:0], por);
    end
    if (play_valid === 1'b1)
    begin
      ok = (pk || mute) && cyc - wr_cyc > 3 && (!sb || (pli == pxl && pri == pxr));
      pq.push_back(ok ? pexp(pli, pxl, srcl) : NA);
      pq.push_back(ok ? pexp(pri, pxr, srcr) : NA);
      pxl = pli;
      pxr = pri;
    end
    if (rchk)
    begin
      chk("rec_l_valid", {15'h0, enl}, {15'h0, rlv});
      chk("rec_r_valid", {15'h0, enr}, {15'h0, rrv});
      if (enl && !hpf) chk("rec_l", ml[15:0], rlo);
      if (enr && !hpf) chk("rec_r", mr[15:0], rro);
    end
    rchk = rec_valid === 1'b1 && cyc - wr_cyc > 3;
    if (rec_valid === 1'b1 && enl) ml = recx(rli, invl, gl);
    if (rec_valid === 1'b1 && enr) mr = recx(rri, invr, gr);
  end

  initial
  begin
    #4000000;
    err_count = err_count + 1;
    finish_test;
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
    begin
      bus(0, ri[i], 16'h0);
      chk("reg_reset", re[i], rd[15:0]);
    end
    bus(1, 8'h44, 16'h0cc0);
    bus(1, 8'h42, 16'h80c0);
    run(100);
    chk("hpf_first", 16'h1, {15'h0, rlo > 900 && rlo < 1000});
    bus(1, 8'h40, 16'h8300);
    run(100);
    chk("hpf_second", 16'h1, {15'h0, rlo < 100 && rlo > -100});
    bus(1, 8'h40, 16'h0000);
    fixed <= 1'b0;
    run(20);
    bus(1, 8'h40, 16'h0003);
    bus(1, 8'h43, 16'h80c0);
    run(20);
    bus(1, 8'h42, 16'h8000);
    run(10);
    bus(0, 8'h42, 16'h0);
    chk("gain_staged", 16'h8000, rd[15:0]);
    bus(1, 8'h43, 16'h81c0);
    run(10);
    bus(1, 8'h42, 16'h81c0);
    bus(1, 8'h40, 16'h0000);
    bus(1, 8'h3a, 16'h0000);
    bus(0, 8'h45, 16'h0);
    chk("unmute_now", 16'hc0c0, rd[15:0]);
    pk = 0;
    bus(1, 8'h32, 16'h0080);
    bus(0, 8'h45, 16'h0);
    chk("pb_pending", 16'hc0c0, rd[15:0]);
    bus(1, 8'h33, 16'h0190);
    bus(0, 8'h45, 16'h0);
    chk("pb_commit", 16'h9080, rd[15:0]);
    bus(1, 8'h33, 16'h00c0);
    bus(1, 8'h32, 16'h01c0);
    pk = 1;
    for (i = 0; i < 4; i = i + 1)
    begin
      bus(1, 8'h3c, 16'(i) * 16'h1400);
      run(10);
    end
    bus(1, 8'h3c, 16'h1400);
    fixed <= 1'b1;
    fix_val <= 16'sd30000;
    run(5);
    fix_val <= -16'sd30000;
    run(5);
    fix_val <= 16'sd1000;
    bus(1, 8'h3c, 16'h0000);
    bus(1, 8'h3b, 16'h1000);
    run(5);
    bus(1, 8'h3a, 16'h4000);
    pk = 0;
    bus(1, 8'h3b, 16'h4000);
    bus(1, 8'h3a, 16'h0000);
    run(32);
    bus(0, 8'h45, 16'h0);
    chk("ramp_fast", 16'h1010, rd[15:0]);
    bus(1, 8'h3a, 16'h4000);
    bus(1, 8'h3b, 16'h6000);
    bus(1, 8'h3a, 16'h0000);
    run(32);
    bus(0, 8'h45, 16'h0);
    chk("ramp_slow", 16'h0101, rd[15:0]);
    finish_test;
  end
endmodule
